// ---- hw/vbcc_top.sv ----
/*
 * Control logic for blanking, clamp polarity, deferred level updates and
 * software reset of a video pre-amplifier.
 * Assumes the serial slave decodes transfers and presents register writes
 * as one-cycle strobes and reads by address; video timing pins are
 * asynchronous and are synchronised here.
 */
// Function
// - With osd-only set, active video is blanked and only the OSD window shows; clear passes video.
// - With vertical blank enable set, vertical blank is ORed with horizontal blank at the output.
// - With vertical blank enable set, contrast and level-4 writes wait for vertical retrace.
// - With vertical blank enable clear, no vertical blanking and level writes apply at once.
// - Io switch set drives the level-4 converter on the shared pin; clear makes it a vblank input.
// - The level-4 value may still be mixed internally while its pin output is off.
// - With vertical blank enable and io switch both set, vblank comes from the sandcastle input.
// - Clamp polarity clear means positive-going clamp, set means negative-going.
// - Soft reset loads defaults into every register except the reset register.
// - Soft reset aborts internal work but leaves serial bus transfers alone.
// - The soft reset bit clears itself when the reset is complete.
// - Mix select set adds half the level-4 value to each of the first three converters.
`timescale 1ns/1ps
`default_nettype none

module vbcc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire vbcc_pkg::vbcc_wr_type reg_wr,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    input wire logic hblank_pin,
    input wire logic shared_pin_in,
    input wire logic sandcastle_vblank_pin,
    input wire logic clamp_pin,
    input wire logic fourth_converter_mix_select,
    input wire logic [7:0] first_three_converters_in [3],
    output logic video_blank,
    output logic osd_only_blank,
    output logic clamp_active,
    output logic shared_pin_oe_n,
    output logic [7:0] fourth_level_converter,
    output logic [6:0] contrast_active,
    output logic [8:0] first_three_converters [3],
    output vbcc_pkg::vbcc_ctrl_type ctrl_out,
    output logic soft_reset_active
);
    import vbcc_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pins_meta_r;
    logic [3:0] pins_sync_r;
    logic vblank_prev_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pins_meta_r <= 4'h0;
            pins_sync_r <= 4'h0;
        end else begin
            pins_meta_r <= {clamp_pin, sandcastle_vblank_pin, shared_pin_in, hblank_pin};
            pins_sync_r <= pins_meta_r;
        end
    end

    logic hblank_s;
    logic vblank_pin_s;
    logic sandcastle_s;
    logic clamp_s;
    assign hblank_s = pins_sync_r[0];
    assign vblank_pin_s = pins_sync_r[1];
    assign sandcastle_s = pins_sync_r[2];
    assign clamp_s = pins_sync_r[3];

    // ------------------------------------------------------------------
    // Soft reset sequencer
    // ------------------------------------------------------------------
    vbcc_state_type state_r;
    vbcc_state_type state_nxt;
    logic [1:0] soft_reset_trigger_cnt_r;
    logic [1:0] soft_reset_trigger_cnt_nxt;
    logic soft_reset_trigger_req;

    function automatic logic is_write(input vbcc_wr_type w, input logic [7:0] a);
        is_write = w.wr_strobe && (w.addr == a);
    endfunction

    assign soft_reset_trigger_req = is_write(reg_wr, VBCC_ADDR_SOFT_RESET) && reg_wr.wdata[VBCC_BIT_SOFT_RESET];

    always_comb begin
        state_nxt = state_r;
        soft_reset_trigger_cnt_nxt = soft_reset_trigger_cnt_r;
        case (state_r)
            VBCC_ST_IDLE: begin
                if (soft_reset_trigger_req) begin
                    state_nxt = VBCC_ST_RESET;
                    soft_reset_trigger_cnt_nxt = VBCC_SOFT_RESET_TRIGGER_CYCLES;
                end
            end
            VBCC_ST_RESET: begin
                // Self-clearing once the count runs out
                soft_reset_trigger_cnt_nxt = soft_reset_trigger_cnt_r - 2'h1;
                if (soft_reset_trigger_cnt_r == 2'h1) begin
                    state_nxt = VBCC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = VBCC_ST_IDLE;
                soft_reset_trigger_cnt_nxt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= VBCC_ST_IDLE;
            soft_reset_trigger_cnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            soft_reset_trigger_cnt_r <= soft_reset_trigger_cnt_nxt;
        end
    end

    logic in_soft_reset_trigger;
    assign in_soft_reset_trigger = (state_r == VBCC_ST_RESET);
    // Serial transfers are not in this block, so only local work is aborted
    assign soft_reset_active = in_soft_reset_trigger;

    // ------------------------------------------------------------------
    // Vertical blank source and edge
    // ------------------------------------------------------------------
    vbcc_ctrl_type ctrl_r;
    vbcc_ctrl_type ctrl_nxt;
    logic vblank_src;
    logic vblank_gated;
    logic vblank_start;

    always_comb begin
        if (ctrl_r.converter_io_switch) begin
            vblank_src = sandcastle_s;
        end else begin
            vblank_src = vblank_pin_s;
        end
    end

    // Internal vertical blanking off while the enable is clear
    assign vblank_gated = ctrl_r.vertical_blank_enable & vblank_src;
    assign vblank_start = vblank_gated & ~vblank_prev_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vblank_prev_r <= 1'b0;
        end else begin
            vblank_prev_r <= vblank_gated;
        end
    end

    // ------------------------------------------------------------------
    // Registers: control, holding and active values
    // ------------------------------------------------------------------
    logic [6:0] contrast_hold_r;
    logic [6:0] contrast_hold_nxt;
    logic [7:0] level4_hold_r;
    logic [7:0] level4_hold_nxt;
    logic [6:0] contrast_act_r;
    logic [6:0] contrast_act_nxt;
    logic [7:0] level4_act_r;
    logic [7:0] level4_act_nxt;
    logic pending_r;
    logic pending_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        contrast_hold_nxt = contrast_hold_r;
        level4_hold_nxt = level4_hold_r;
        contrast_act_nxt = contrast_act_r;
        level4_act_nxt = level4_act_r;
        pending_nxt = pending_r;
        if (in_soft_reset_trigger) begin
            // Defaults everywhere; pending update dropped
            ctrl_nxt = vbcc_ctrl_type'(VBCC_BLANK_CLAMP_RST[3:0]);
            contrast_hold_nxt = VBCC_CONTRAST_RST;
            level4_hold_nxt = VBCC_LEVEL4_RST;
            contrast_act_nxt = VBCC_CONTRAST_RST;
            level4_act_nxt = VBCC_LEVEL4_RST;
            pending_nxt = 1'b0;
        end else begin
            if (is_write(reg_wr, VBCC_ADDR_BLANK_CLAMP)) begin
                ctrl_nxt = vbcc_ctrl_type'(reg_wr.wdata[3:0]);
            end
            if (is_write(reg_wr, VBCC_ADDR_CONTRAST)) begin
                contrast_hold_nxt = reg_wr.wdata[VBCC_CONTRAST_W-1:0];
                pending_nxt = 1'b1;
            end
            if (is_write(reg_wr, VBCC_ADDR_LEVEL4)) begin
                level4_hold_nxt = reg_wr.wdata;
                pending_nxt = 1'b1;
            end
            if (!ctrl_r.vertical_blank_enable) begin
                // Immediate path follows the holding value
                contrast_act_nxt = contrast_hold_nxt;
                level4_act_nxt = level4_hold_nxt;
                pending_nxt = 1'b0;
            end else if (pending_r && vblank_start) begin
                // A write in this very cycle stays pending for the next blank
                contrast_act_nxt = contrast_hold_r;
                level4_act_nxt = level4_hold_r;
                pending_nxt = pending_nxt & (contrast_hold_nxt != contrast_hold_r
                    || level4_hold_nxt != level4_hold_r);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= vbcc_ctrl_type'(VBCC_BLANK_CLAMP_RST[3:0]);
            contrast_hold_r <= VBCC_CONTRAST_RST;
            level4_hold_r <= VBCC_LEVEL4_RST;
            contrast_act_r <= VBCC_CONTRAST_RST;
            level4_act_r <= VBCC_LEVEL4_RST;
            pending_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            contrast_hold_r <= contrast_hold_nxt;
            level4_hold_r <= level4_hold_nxt;
            contrast_act_r <= contrast_act_nxt;
            level4_act_r <= level4_act_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    logic [7:0] rd_nxt;

    always_comb begin
        case (reg_rd_addr)
            VBCC_ADDR_BLANK_CLAMP: rd_nxt = {4'h0, ctrl_r};
            VBCC_ADDR_SOFT_RESET: rd_nxt = {7'h00, in_soft_reset_trigger};
            VBCC_ADDR_CONTRAST: rd_nxt = {1'b0, contrast_hold_r};
            VBCC_ADDR_LEVEL4: rd_nxt = level4_hold_r;
            default: rd_nxt = VBCC_ZERO_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rd_data <= VBCC_ZERO_BYTE;
        end else begin
            reg_rd_data <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Video control outputs
    // ------------------------------------------------------------------
    logic blank_nxt;
    logic clamp_nxt;
    logic [8:0] mix_nxt [3];
    logic [8:0] mix_r [3];
    logic blank_r;
    logic clamp_r;

    function automatic logic [8:0] mix_level(input logic [7:0] base, input logic [7:0] l4,
                                             input logic en);
        mix_level = {1'b0, base} + (en ? {2'h0, l4[7:1]} : 9'h000);
    endfunction

    always_comb begin
        // OSD-only blanks active video regardless of timing
        blank_nxt = hblank_s | vblank_gated | ctrl_r.osd_only_blank;
        // Clamp normalised to active high
        clamp_nxt = clamp_s ^ ctrl_r.clamp_polarity_select;
        for (int i = 0; i < 3; i++) begin
            // Mixing ignores the io switch, so it works with the pin off
            mix_nxt[i] = mix_level(first_three_converters_in[i], level4_act_r,
                                   fourth_converter_mix_select);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blank_r <= 1'b0;
            clamp_r <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                mix_r[i] <= 9'h000;
            end
        end else begin
            blank_r <= blank_nxt;
            clamp_r <= clamp_nxt;
            for (int i = 0; i < 3; i++) begin
                mix_r[i] <= mix_nxt[i];
            end
        end
    end

    assign video_blank = blank_r;
    assign clamp_active = clamp_r;
    assign first_three_converters = mix_r;
    assign osd_only_blank = ctrl_r.osd_only_blank;
    // Drive low-enable: pin driven while io switch is set
    assign shared_pin_oe_n = ~ctrl_r.converter_io_switch;
    assign fourth_level_converter = level4_act_r;
    assign contrast_active = contrast_act_r;
    assign ctrl_out = ctrl_r;

endmodule

`default_nettype wire

// ---- hw/vbcc_pkg.sv ----
/*
 * Package for the video blank and clamp control bank: register addresses,
 * field positions, reset values and shared types.
 * Assumes an upstream serial slave that hands over byte-wide register
 * writes as one-cycle strobes on ref_clk and reads by address.
 */
`default_nettype none

package vbcc_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] VBCC_ADDR_CONTRAST = 8'h03;
    localparam logic [7:0] VBCC_ADDR_LEVEL4 = 8'h07;
    localparam logic [7:0] VBCC_ADDR_BLANK_CLAMP = 8'h0B;
    localparam logic [7:0] VBCC_ADDR_SOFT_RESET = 8'h0F;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int VBCC_BIT_OSD_ONLY = 0;
    localparam int VBCC_BIT_VBLANK_EN = 1;
    localparam int VBCC_BIT_IO_SWITCH = 2;
    localparam int VBCC_BIT_CLAMP_POL = 3;
    localparam int VBCC_BIT_SOFT_RESET = 0;
    localparam int VBCC_CONTRAST_W = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] VBCC_BLANK_CLAMP_RST = 8'h04;
    localparam logic [6:0] VBCC_CONTRAST_RST = 7'h00;
    localparam logic [7:0] VBCC_LEVEL4_RST = 8'h80;
    localparam logic [7:0] VBCC_ZERO_BYTE = 8'h00;

    // Cycles the soft reset stays asserted
    localparam logic [1:0] VBCC_SOFT_RESET_TRIGGER_CYCLES = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic clamp_polarity_select;
        logic converter_io_switch;
        logic vertical_blank_enable;
        logic osd_only_blank;
    } vbcc_ctrl_type;

    typedef struct packed {
        logic wr_strobe;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vbcc_wr_type;

    typedef enum logic [1:0] {
        VBCC_ST_IDLE = 2'b01,
        VBCC_ST_RESET = 2'b10
    } vbcc_state_type;

endpackage

`default_nettype wire

// ---- bench/vbcc_sva.sv ----
/* Concurrent checks on the blank, clamp and soft reset control bank.
   Sees only the ports of vbcc_top and is bound to it below. */
`timescale 1ns/1ps
`default_nettype none
module vbcc_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire vbcc_pkg::vbcc_wr_type reg_wr,
    input wire logic clamp_pin,
    input wire logic fourth_converter_mix_select,
    input wire logic [7:0] first_three_converters_in [3],
    input wire logic video_blank,
    input wire logic osd_only_blank,
    input wire logic clamp_active,
    input wire logic shared_pin_oe_n,
    input wire logic [7:0] fourth_level_converter,
    input wire logic [6:0] contrast_active,
    input wire logic [8:0] first_three_converters [3],
    input wire vbcc_pkg::vbcc_ctrl_type ctrl_out,
    input wire logic soft_reset_active
);
    import vbcc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic w_con;
    logic w_soft_reset_trigger;
    assign w_con = reg_wr.wr_strobe && reg_wr.addr == VBCC_ADDR_CONTRAST && !soft_reset_active;
    assign w_soft_reset_trigger = reg_wr.wr_strobe && reg_wr.addr == VBCC_ADDR_SOFT_RESET && reg_wr.wdata[0];

    AST_OSD_BLANK: assert property (osd_only_blank |=> video_blank)
        else $error("osd only bit did not blank video");
    AST_PIN_ROLE: assert property ($stable(ctrl_out) |->
        shared_pin_oe_n == !ctrl_out.converter_io_switch)
        else $error("shared pin direction disagrees with io switch");
    AST_SOFT_RESET_TRIGGER_START: assert property (w_soft_reset_trigger && !soft_reset_active |=> soft_reset_active)
        else $error("soft reset write did not start a reset");
    AST_SOFT_RESET_TRIGGER_LEN: assert property ($rose(soft_reset_active) |->
        soft_reset_active[*2] ##1 !soft_reset_active)
        else $error("soft reset did not clear itself after two cycles");
    AST_SOFT_RESET_TRIGGER_DEFAULTS: assert property (soft_reset_active |=> ctrl_out == VBCC_BLANK_CLAMP_RST[3:0]
        && contrast_active == VBCC_CONTRAST_RST && fourth_level_converter == VBCC_LEVEL4_RST)
        else $error("registers not at defaults during soft reset");
    AST_IMMED: assert property (w_con && !ctrl_out.vertical_blank_enable |=>
        contrast_active == $past(reg_wr.wdata[6:0]))
        else $error("contrast write not applied at once");
    AST_DEFER: assert property (ctrl_out.vertical_blank_enable && $past(ctrl_out.vertical_blank_enable)
        && !$past(soft_reset_active) && $changed(contrast_active) |-> video_blank)
        else $error("contrast changed outside vertical blank");
    AST_MIX: assert property (!$past(rst) |-> first_three_converters[0] ==
        {1'b0, $past(first_three_converters_in[0])} + ($past(fourth_converter_mix_select) ?
        {2'b00, $past(fourth_level_converter[7:1])} : 9'h000))
        else $error("converter mix sum wrong");
    AST_CLAMP: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
        clamp_active == ($past(clamp_pin, 3) ^ $past(ctrl_out.clamp_polarity_select)))
        else $error("clamp polarity not applied");
endmodule
bind vbcc_top vbcc_sva i_vbcc_sva (.ref_clk, .rst, .reg_wr, .clamp_pin,
    .fourth_converter_mix_select, .first_three_converters_in, .video_blank, .osd_only_blank,
    .clamp_active, .shared_pin_oe_n, .fourth_level_converter, .contrast_active,
    .first_three_converters, .ctrl_out, .soft_reset_active);
`default_nettype wire

// ---- bench/vbcc_host.sv ----
/* Host controller model: byte writes and reads toward the control bank.
   Assumes requests are launched on falling edges of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module vbcc_host (
    input wire logic ref_clk,
    output var vbcc_pkg::vbcc_wr_type reg_wr,
    output logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data
);
    import vbcc_pkg::*;
    // Idle cycles before each write, for a slow host
    int idle = 0;
    initial begin
        reg_wr = '0;
        reg_rd_addr = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == VBCC_ADDR_BLANK_CLAMP && d[2:1] == 2'b11) begin
            d[3] = 1'b0;
        end
        repeat (idle) @(negedge ref_clk);
        @(negedge ref_clk);
        reg_wr = '{wr_strobe: 1'b1, addr: a, wdata: d};
        @(negedge ref_clk);
        // Stale data never lingers after the strobe
        reg_wr = '{wr_strobe: 1'b0, addr: a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_rd_addr = a;
        @(negedge ref_clk);
        d = reg_rd_data;
    endtask
endmodule
`default_nettype wire

// ---- bench/video_blank_clamp_control_tb.sv ----
/* Self-checking bench for vbcc_top, driven through the host model.
   Assumes vbcc_pkg, vbcc_host and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module video_blank_clamp_control_tb;
    import vbcc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    vbcc_wr_type reg_wr;
    logic [7:0] reg_rd_addr;
    logic [7:0] reg_rd_data;
    logic hblank_pin = 1'b0;
    logic shared_pin_in = 1'b0;
    logic sandcastle_vblank_pin = 1'b0;
    logic clamp_pin = 1'b0;
    logic mix = 1'b0;
    logic [7:0] cin [3] = '{default: 8'h00};
    logic [8:0] cout [3];
    logic video_blank;
    logic osd_only_blank;
    logic clamp_active;
    logic oe_n;
    logic soft_reset_trigger;
    logic [7:0] l4;
    logic [6:0] con;
    vbcc_ctrl_type ctrl;
    logic [7:0] al [5] = '{8'h0B, 8'h03, 8'h07, 8'h0F, 8'h55};
    logic [7:0] d;
    int miscompares = 0;
    int checked = 0;
    int seed = 30;
    int oc;
    int ol;
    int mdl [int];

    always #20 ref_clk = ~ref_clk;

    vbcc_host i_vbcc_host (.ref_clk, .reg_wr, .reg_rd_addr, .reg_rd_data);
    vbcc_top i_vbcc_top (.ref_clk, .rst, .reg_wr, .reg_rd_addr, .reg_rd_data, .hblank_pin,
        .shared_pin_in, .sandcastle_vblank_pin, .clamp_pin, .fourth_converter_mix_select(mix),
        .first_three_converters_in(cin), .video_blank, .osd_only_blank, .clamp_active,
        .shared_pin_oe_n(oe_n), .fourth_level_converter(l4), .contrast_active(con),
        .first_three_converters(cout), .ctrl_out(ctrl), .soft_reset_active(soft_reset_trigger));

    task automatic chk(input logic [8:0] got, input int exp);
        checked++;
        if (got !== 9'(exp)) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, 9'(exp));
        end
    endtask
    task automatic mdl_defaults;
        mdl.delete();
        mdl[11] = 4;
        mdl[7] = 128;
        mdl[3] = 0;
    endtask
    task automatic rdc(input logic [7:0] a);
        i_vbcc_host.rd(a, d);
        chk(d, mdl.exists(a) ? mdl[a] : 0);
    endtask
    task automatic wrm(input logic [7:0] a, input logic [7:0] v);
        i_vbcc_host.wr(a, v);
        // Model mirrors the host clearing clamp polarity for sandcastle use
        if (a == 8'h0B) v = v & ((v[2:1] == 2'b11) ? 8'h07 : 8'h0F);
        if (a == 8'h03) v = v & 8'h7F;
        mdl[a] = v;
    endtask
    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        mdl_defaults();
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        foreach (al[i]) rdc(al[i]);
        chk(oe_n, 0);
        repeat (8) begin
            wrm(8'h0B, 8'($random(seed)));
            rdc(8'h0B);
            chk(osd_only_blank, mdl[11][0]);
            chk(video_blank, mdl[11][0]);
            chk(oe_n, !mdl[11][2]);
            chk(ctrl, mdl[11]);
        end
        wrm(8'h0B, 8'h00);
        wrm(8'h03, 8'($random(seed)));
        chk(con, mdl[3]);
        wrm(8'h07, 8'($random(seed)));
        chk(l4, mdl[7]);
        mix = 1'b1;
        foreach (cin[i]) cin[i] = 8'($random(seed));
        repeat (2) @(negedge ref_clk);
        foreach (cin[i]) chk(cout[i], cin[i] + (mdl[7] >> 1));
        mix = 1'b0;
        repeat (2) @(negedge ref_clk);
        foreach (cin[i]) chk(cout[i], cin[i]);
        hblank_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(video_blank, 1);
        hblank_pin = 1'b0;
        wrm(8'h0B, 8'h02);
        oc = mdl[3];
        ol = mdl[7];
        wrm(8'h03, 8'(oc ^ 8'h55));
        wrm(8'h07, 8'(ol ^ 8'hA5));
        rdc(8'h03);
        chk(con, oc);
        chk(l4, ol);
        shared_pin_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(con, mdl[3]);
        chk(l4, mdl[7]);
        chk(video_blank, 1);
        shared_pin_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(video_blank, 0);
        wrm(8'h0B, 8'h0E);
        rdc(8'h0B);
        shared_pin_in = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(video_blank, 0);
        sandcastle_vblank_pin = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(video_blank, 1);
        {shared_pin_in, sandcastle_vblank_pin} = 2'b00;
        for (int p = 0; p < 2; p++) begin
            wrm(8'h0B, p[0] ? 8'h08 : 8'h00);
            clamp_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
            chk(clamp_active, !p[0]);
            clamp_pin = 1'b0;
            repeat (4) @(negedge ref_clk);
            chk(clamp_active, p[0]);
        end
        i_vbcc_host.idle = 2;
        wrm(8'h0B, 8'h09);
        wrm(8'h03, 8'($random(seed)));
        i_vbcc_host.wr(8'h0F, 8'h01);
        chk(soft_reset_trigger, 1);
        mdl_defaults();
        rdc(8'h07);
        repeat (2) @(negedge ref_clk);
        foreach (al[i]) rdc(al[i]);
        chk(con, 0);
        chk(osd_only_blank, 0);
        chk(soft_reset_trigger, 0);
        end_sim();
    end

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
